// file: src/fbalu_consts.svh
// constants for the four-bit arithmetic logic unit
`ifndef FBALU_CONSTS_SVH
`define FBALU_CONSTS_SVH

// ==========================================
// widths
`define FBALU_OPND_W 4
`define FBALU_SEL_W 3
`define FBALU_RES_W 8

// ==========================================
// operation codes
`define FBALU_OP_ADD 3'h0
`define FBALU_OP_SUB 3'h1
`define FBALU_OP_MUL 3'h2
`define FBALU_OP_DIV 3'h3
`define FBALU_OP_AND 3'h4
`define FBALU_OP_OR 3'h5
`define FBALU_OP_NOT 3'h6
`define FBALU_OP_XOR 3'h7

// ==========================================
// reset values
`define FBALU_RES_RST 8'h00
`define FBALU_FLAG_RST 1'h0
`define FBALU_ZERO_RST 1'h1

`endif

// file: src/fbalu_core.sv
// combinational compute core of the four-bit arithmetic logic unit
`include "fbalu_consts.svh"
module fbalu_core #(
   parameter int OPND_W = `FBALU_OPND_W,
   parameter int RES_W = `FBALU_RES_W
) (
   // operands and select
   input wire logic [OPND_W-1:0] opnd_a,
   input wire logic [OPND_W-1:0] opnd_b,
   input wire fbalu_pkg::fbalu_op_t op_sel,
   // answer
   output logic [RES_W-1:0] result_word,
   output logic carry,
   output logic zero
);
   // ==========================================
   // zero extension of an operand-wide value
   function automatic logic [RES_W-1:0] zext(input logic [OPND_W-1:0] v);
      zext = {{(RES_W-OPND_W){1'b0}}, v};
   endfunction

   logic [OPND_W:0] sum_w;
   logic [OPND_W:0] diff_w;
   logic [2*OPND_W-1:0] prod_w;

   always_comb begin
      sum_w = {1'b0, opnd_a} + {1'b0, opnd_b};
      diff_w = {1'b0, opnd_a} - {1'b0, opnd_b};
      prod_w = {{OPND_W{1'b0}}, opnd_a} * {{OPND_W{1'b0}}, opnd_b};
      result_word = `FBALU_RES_RST;
      carry = `FBALU_FLAG_RST;
      unique case (op_sel)
         fbalu_pkg::OP_ADD: begin
            result_word = RES_W'(sum_w);
            carry = sum_w[OPND_W];
         end
         fbalu_pkg::OP_SUB: begin
            // borrow counts as the overflow of a subtraction
            result_word = zext(diff_w[OPND_W-1:0]);
            carry = diff_w[OPND_W];
         end
         fbalu_pkg::OP_MUL: begin
            result_word = RES_W'(prod_w);
            // product of two operands never exceeds the result width
            carry = |prod_w[2*OPND_W-1:OPND_W];
         end
         fbalu_pkg::OP_DIV: begin
            // divide by zero gives zero rather than a bogus quotient
            result_word = (opnd_b == '0) ? '0 : zext(opnd_a / opnd_b);
         end
         fbalu_pkg::OP_AND: result_word = zext(opnd_a & opnd_b);
         fbalu_pkg::OP_OR: result_word = zext(opnd_a | opnd_b);
         fbalu_pkg::OP_NOT: result_word = zext(~opnd_a);
         fbalu_pkg::OP_XOR: result_word = zext(opnd_a ^ opnd_b);
      endcase
      zero = (result_word == '0);
   end
endmodule

// file: src/fbalu_pkg.sv
// types for the four-bit arithmetic logic unit
package fbalu_pkg;
   typedef enum logic [2:0] {
      OP_ADD = 3'b000,
      OP_SUB = 3'b001,
      OP_MUL = 3'b010,
      OP_DIV = 3'b011,
      OP_AND = 3'b100,
      OP_OR = 3'b101,
      OP_NOT = 3'b110,
      OP_XOR = 3'b111
   } fbalu_op_t;
endpackage

// file: src/fbalu_top.sv
// pin-facing top of the four-bit arithmetic logic unit
// Function
// - two separate 4-bit operands feed every operation except not, which uses only the first operand
// - 3-bit select picks one function; the driver presents the code
// - codes 0..7 are add, sub, mul, div, and, or, not, xor
// - add and mul results drive the 8-bit result word; sub and div give 4-bit values, zero-extended
// - carry flag set on arithmetic overflow, clear otherwise
// - logic functions work bit by bit on both operands, except not, which inverts the first operand only
// - zero flag set exactly when result word is zero
`include "fbalu_consts.svh"
module fbalu_top #(
   parameter int OPND_W = `FBALU_OPND_W,
   parameter int SEL_W = `FBALU_SEL_W,
   parameter int RES_W = `FBALU_RES_W
) (
   // clock, reset, enable
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic CLK_EN,
   // pins from the tester
   input wire logic [OPND_W-1:0] OPND_A,
   input wire logic [OPND_W-1:0] OPND_B,
   input wire logic [SEL_W-1:0] OP_SEL,
   // answer
   output logic [RES_W-1:0] RESULT_WORD,
   output logic CARRY_FLAG,
   output logic ZERO_FLAG
);
   // ==========================================
   // first operand synchroniser
   logic [OPND_W-1:0] a_m_q;
   logic [OPND_W-1:0] a_m_d;
   logic [OPND_W-1:0] a_s_q;
   logic [OPND_W-1:0] a_s_d;

   // first stage may go metastable; only the second stage reads it
   always_comb begin
      a_m_d = a_m_q;
      if (CLK_EN) begin
         a_m_d = OPND_A;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         a_m_q <= '0;
      end else begin
         a_m_q <= a_m_d;
      end
   end

   always_comb begin
      a_s_d = a_s_q;
      if (CLK_EN) begin
         a_s_d = a_m_q;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         a_s_q <= '0;
      end else begin
         a_s_q <= a_s_d;
      end
   end

   // ==========================================
   // second operand synchroniser
   logic [OPND_W-1:0] b_m_q;
   logic [OPND_W-1:0] b_m_d;
   logic [OPND_W-1:0] b_s_q;
   logic [OPND_W-1:0] b_s_d;

   // per-bit sync only: a pin change can land one cycle apart across bits
   always_comb begin
      b_m_d = b_m_q;
      if (CLK_EN) begin
         b_m_d = OPND_B;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         b_m_q <= '0;
      end else begin
         b_m_q <= b_m_d;
      end
   end

   always_comb begin
      b_s_d = b_s_q;
      if (CLK_EN) begin
         b_s_d = b_m_q;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         b_s_q <= '0;
      end else begin
         b_s_q <= b_s_d;
      end
   end

   // ==========================================
   // operation code synchroniser
   logic [SEL_W-1:0] s_m_q;
   logic [SEL_W-1:0] s_m_d;
   logic [SEL_W-1:0] s_s_q;
   logic [SEL_W-1:0] s_s_d;

   always_comb begin
      s_m_d = s_m_q;
      if (CLK_EN) begin
         s_m_d = OP_SEL;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         s_m_q <= '0;
      end else begin
         s_m_q <= s_m_d;
      end
   end

   always_comb begin
      s_s_d = s_s_q;
      if (CLK_EN) begin
         s_s_d = s_m_q;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         s_s_q <= '0;
      end else begin
         s_s_q <= s_s_d;
      end
   end

   // ==========================================
   // compute
   fbalu_pkg::fbalu_op_t op_code;
   logic [RES_W-1:0] core_res;
   logic core_carry;
   logic core_zero;

   // every code is a named operation, so the cast cannot give an unnamed value
   assign op_code = fbalu_pkg::fbalu_op_t'(s_s_q);

   fbalu_core #(
      .OPND_W(OPND_W),
      .RES_W(RES_W)
   ) u_core (
      .opnd_a(a_s_q),
      .opnd_b(b_s_q),
      .op_sel(op_code),
      .result_word(core_res),
      .carry(core_carry),
      .zero(core_zero)
   );

   // ==========================================
   // result register
   // registered outputs cost a cycle but keep pins glitch-free
   logic [RES_W-1:0] res_q;
   logic [RES_W-1:0] res_d;

   always_comb begin
      res_d = res_q;
      if (CLK_EN) begin
         res_d = core_res;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         res_q <= `FBALU_RES_RST;
      end else begin
         res_q <= res_d;
      end
   end

   // ==========================================
   // carry register
   logic carry_q;
   logic carry_d;

   always_comb begin
      carry_d = carry_q;
      if (CLK_EN) begin
         carry_d = core_carry;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         carry_q <= `FBALU_FLAG_RST;
      end else begin
         carry_q <= carry_d;
      end
   end

   // ==========================================
   // zero register
   // reset result is zero, so the flag reads set
   logic zero_q;
   logic zero_d;

   always_comb begin
      zero_d = zero_q;
      if (CLK_EN) begin
         zero_d = core_zero;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         zero_q <= `FBALU_ZERO_RST;
      end else begin
         zero_q <= zero_d;
      end
   end

   // ==========================================
   // pins
   assign RESULT_WORD = res_q;
   assign CARRY_FLAG = carry_q;
   assign ZERO_FLAG = zero_q;
endmodule

// file: tb/fbalu_chk.sv
// checker of the alu answer against its delayed inputs
module fbalu_chk (
   // clock and control
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic CLK_EN,
   // pins and answer
   input wire logic [3:0] OPND_A,
   input wire logic [3:0] OPND_B,
   input wire logic [2:0] OP_SEL,
   input wire logic [7:0] RESULT_WORD,
   input wire logic CARRY_FLAG,
   input wire logic ZERO_FLAG
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [10:0] p1_q, p2_q, p3_q;
   logic [1:0] n_q;
   wire [3:0] a = p3_q[3:0];
   wire [3:0] b = p3_q[7:4];
   wire [2:0] s = p3_q[10:8];
   wire ok = n_q == 2'h3;
   // mirrors the three-edge latency; frozen with the enable like the design
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         n_q <= 2'h0;
      end else if (CLK_EN) begin
         n_q <= ok ? n_q : n_q + 2'h1;
         p1_q <= {OP_SEL, OPND_B, OPND_A};
         p2_q <= p1_q;
         p3_q <= p2_q;
      end
   end
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   add_sum_a: assert property (ok && s == 3'h0 |-> RESULT_WORD == a + b && CARRY_FLAG == (a + b > 15))
      else $error("bad sum");
   sub_wrap_a: assert property (ok && s == 3'h1 |-> RESULT_WORD == {4'h0, a - b} && CARRY_FLAG == (a < b))
      else $error("bad difference");
   mul_prod_a: assert property (ok && s == 3'h2 |-> RESULT_WORD == a * b && CARRY_FLAG == (a * b > 15))
      else $error("bad product");
   div_quot_a: assert property (ok && s == 3'h3 |-> RESULT_WORD == (b == 4'h0 ? 8'h00 : a / b) && !CARRY_FLAG)
      else $error("bad quotient");
   and_bits_a: assert property (ok && s == 3'h4 |-> RESULT_WORD == {4'h0, a & b} && !CARRY_FLAG)
      else $error("bad and");
   or_bits_a: assert property (ok && s == 3'h5 |-> RESULT_WORD == {4'h0, a | b} && !CARRY_FLAG)
      else $error("bad or");
   not_first_a: assert property (ok && s == 3'h6 |-> RESULT_WORD == {4'h0, ~a} && !CARRY_FLAG)
      else $error("bad invert");
   xor_bits_a: assert property (ok && s == 3'h7 |-> RESULT_WORD == {4'h0, a ^ b} && !CARRY_FLAG)
      else $error("bad xor");
   zero_flag_a: assert property (ZERO_FLAG == (RESULT_WORD == 8'h00))
      else $error("bad zero flag");
endmodule
bind fbalu_top fbalu_chk u_chk (.SYS_CLK(SYS_CLK), .RST(RST), .CLK_EN(CLK_EN), .OPND_A(OPND_A), .OPND_B(OPND_B),
   .OP_SEL(OP_SEL), .RESULT_WORD(RESULT_WORD), .CARRY_FLAG(CARRY_FLAG), .ZERO_FLAG(ZERO_FLAG));

// file: tb/fbalu_pins.sv
// tester pins presenting operands and code to the alu
module fbalu_pins (
   // requests from the bench
   input wire logic [3:0] a_req,
   input wire logic [3:0] b_req,
   input wire logic [2:0] sel_req,
   // chip pins
   output logic [3:0] a_pin,
   output logic [3:0] b_pin,
   output logic [2:0] sel_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   assign a_pin = a_req;
   assign b_pin = b_req;
   // code held as a level until the bench moves it
   assign sel_pin = sel_req;
endmodule

// file: tb/four_bit_alu_tb.sv
// self-checking bench of the four-bit alu
module four_bit_alu_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic en_q = 1'b1;
   logic [3:0] a_q = 4'h0, b_q = 4'h0, opnd_a, opnd_b;
   logic [2:0] s_q = 3'h0, op_sel;
   logic [7:0] result_word;
   logic carry_flag, zero_flag;
   int fail_count = 0;
   int n_tests = 0;
   fbalu_pins u_pins (.a_req(a_q), .b_req(b_q), .sel_req(s_q), .a_pin(opnd_a), .b_pin(opnd_b), .sel_pin(op_sel));
   fbalu_top u_dut (.SYS_CLK(sys_clk), .RST(rst), .CLK_EN(en_q), .OPND_A(opnd_a), .OPND_B(opnd_b), .OP_SEL(op_sel),
      .RESULT_WORD(result_word), .CARRY_FLAG(carry_flag), .ZERO_FLAG(zero_flag));
   initial forever #2.5 sys_clk = ~sys_clk;
   task automatic conclude;
      if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // drives at an edge, then looks three edges on
   task automatic run(input logic [3:0] a, b, input logic [2:0] s, input logic [7:0] r, input logic c);
      @(posedge sys_clk);
      a_q <= a;
      b_q <= b;
      s_q <= s;
      repeat (3) @(posedge sys_clk);
      #1;
      check({carry_flag, zero_flag, result_word}, {c, r == 8'h00, r});
   endtask
   task automatic t_arith;
      run(4'hF, 4'hF, 3'h0, 8'h1E, 1'b1);
      run(4'h7, 4'h8, 3'h0, 8'h0F, 1'b0);
      run(4'h3, 4'h5, 3'h1, 8'h0E, 1'b1);
      run(4'h5, 4'h5, 3'h1, 8'h00, 1'b0);
      run(4'hF, 4'hF, 3'h2, 8'hE1, 1'b1);
      run(4'h3, 4'h5, 3'h2, 8'h0F, 1'b0);
      run(4'hF, 4'h2, 3'h3, 8'h07, 1'b0);
      run(4'h9, 4'h0, 3'h3, 8'h00, 1'b0);
   endtask
   task automatic t_logic;
      run(4'hC, 4'hA, 3'h4, 8'h08, 1'b0);
      run(4'hC, 4'hA, 3'h5, 8'h0E, 1'b0);
      run(4'hC, 4'hA, 3'h6, 8'h03, 1'b0);
      run(4'hC, 4'hA, 3'h7, 8'h06, 1'b0);
      run(4'h3, 4'hC, 3'h4, 8'h00, 1'b0);
      run(4'hF, 4'h0, 3'h6, 8'h00, 1'b0);
   endtask
   // enable low freezes the answer while the pins move
   task automatic t_hold;
      run(4'h2, 4'h3, 3'h0, 8'h05, 1'b0);
      @(posedge sys_clk);
      en_q <= 1'b0;
      a_q <= 4'h9;
      s_q <= 3'h2;
      repeat (4) @(posedge sys_clk);
      #1;
      check({carry_flag, zero_flag, result_word}, {1'b0, 1'b0, 8'h05});
      @(posedge sys_clk);
      en_q <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      check({carry_flag, zero_flag, result_word}, {1'b1, 1'b0, 8'h1B});
   endtask
   // reset in mid-run: zero result with the flag set, then the answer returns
   task automatic t_reset;
      run(4'h4, 4'h4, 3'h0, 8'h08, 1'b0);
      @(posedge sys_clk);
      rst <= 1'b1;
      @(posedge sys_clk);
      #1;
      check({carry_flag, zero_flag, result_word}, {1'b0, 1'b1, 8'h00});
      @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      #1;
      check({carry_flag, zero_flag, result_word}, {1'b0, 1'b1, 8'h00});
      repeat (2) @(posedge sys_clk);
      #1;
      check({carry_flag, zero_flag, result_word}, {1'b0, 1'b0, 8'h08});
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      t_arith();
      t_logic();
      t_hold();
      t_reset();
      conclude();
   end
   // whole run needs about 100 cycles
   initial begin
      #20000;
      fail_count++;
      conclude();
   end
endmodule
